// ==== logic/mixed_io_pkg.sv ====
// constants for the mixed input/output diagnostic port
package mixed_io_pkg;
   localparam int          CLK_MHZ        = 200;
   localparam int          US_NS          = 1000;
   localparam int          CLK_PERIOD_NS  = 5;
   localparam int          US_CYCLES      = US_NS / CLK_PERIOD_NS;
   localparam logic [7:0]  IMAGE_OFFSET   = 8'h00;
   localparam logic [7:0]  DIAG_RECORD_NO = 8'h01;
   localparam int          RECORD_LEN     = 20;
   localparam logic [4:0]  REC_FAULT      = 5'h00;
   localparam logic [4:0]  REC_CLASS      = 5'h01;
   localparam logic [4:0]  REC_KIND       = 5'h04;
   localparam logic [4:0]  REC_BITS       = 5'h05;
   localparam logic [4:0]  REC_COUNT      = 5'h06;
   localparam logic [4:0]  REC_STAMP      = 5'h10;
   localparam logic [4:0]  REC_LAST       = 5'h13;
   localparam int          FAULT_MODULE   = 0;
   localparam int          FAULT_INTERNAL = 1;
   localparam int          FAULT_EXTERNAL = 2;
   localparam int          FAULT_OVERLOAD = 4;
   localparam int          FAULT_PARAM    = 7;
   localparam logic [7:0]  CLASS_RESET    = 8'h0f;
   localparam logic [7:0]  KIND_RESET     = 8'h72;
   localparam logic [7:0]  BITS_RESET     = 8'h00;
   localparam logic [7:0]  COUNT_RESET    = 8'h00;
   localparam logic [7:0]  SPARE_RESET    = 8'h00;
   localparam logic [7:0]  OUT_RESET      = 8'h00;
   localparam logic [31:0] STAMP_RESET    = 32'h0000_0000;
endpackage

// ==== logic/us_ticker.sv ====
// free running microsecond counter with its tick divider
`timescale 1ns/1ps
module us_ticker
   import mixed_io_pkg::*;
#(
   parameter int DIV = US_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   output logic [31:0]      count
);
   logic [15:0] div_r;
   logic [15:0] div_nxt;
   logic        tick;
   logic [31:0] count_nxt;

   assign tick      = (div_r == 16'(DIV - 1));
   assign div_nxt   = tick ? 16'h0000 : div_r + 16'h0001;
   // natural wrap at 2^32-1 back to zero
   assign count_nxt = tick ? count + 32'h0000_0001 : count;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_r <= 16'h0000;
         count <= STAMP_RESET;
      end else begin
         div_r <= div_nxt;
         count <= count_nxt;
      end
   end

   a_tick_spacing: assert property (
      @(posedge clk_sys) disable iff (rst)
      tick |=> !tick)
      else $error("tick not one cycle");
   a_count_step: assert property (
      @(posedge clk_sys) disable iff (rst)
      !tick |=> $stable(count))
      else $error("count moved off tick");
   // 32-bit sum also covers the wrap back to zero
   a_count_inc: assert property (
      @(posedge clk_sys) disable iff (rst)
      tick |=> count == $past(count) + 32'h0000_0001)
      else $error("count did not step on tick");
endmodule

// ==== logic/mixed_io_diag_port.sv ====
// digital side of the mixed eight input, eight output module
`timescale 1ns/1ps
// Function
// - input byte at offset zero, bit n shows input channel n.
// - output byte at offset zero drives output channel n from bit n.
// - with interrupt parameter on, raise interrupt on entry into any fault from none; else none.
// - red indicator lit exactly while any output is overloaded.
// - incoming interrupt makes its diagnostic record available.
// - going interrupt issued automatically when the cause disappears, only after an incoming interrupt.
// - record number one request answered with the diagnostic record.
// - record layout fixed: twenty bytes, reserved bytes read zero.
// - fault byte bits 0,1,2,4,7 set on faults; bits 3,5,6 zero.
// - class byte reads 0fh.
// - channel kind byte reads 72h.
// - bits-per-channel and channel-count bytes read 00h.
// - timestamp holds ticker value captured at the event.
// - 32-bit microsecond ticker from zero, wrapping.
module mixed_io_diag_port
   import mixed_io_pkg::*;
#(
   parameter int US_DIV = US_CYCLES
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [7:0] sense_channel,
   input  wire logic [7:0] overload,
   input  wire logic       diag_irq_enable,
   input  wire logic       module_failure,
   input  wire logic       internal_error,
   input  wire logic       external_error,
   input  wire logic       param_error,
   input  wire logic       out_wr,
   input  wire logic [7:0] out_addr,
   input  wire logic [7:0] out_wdata,
   input  wire logic       in_rd,
   input  wire logic [7:0] in_addr,
   input  wire logic       rec_rd,
   input  wire logic [7:0] rec_number,
   input  wire logic [4:0] rec_index,
   input  wire logic       irq_ack,
   output logic [7:0]      input_image,
   output logic [7:0]      output_image,
   output logic [7:0]      drive_channel,
   output logic [7:0]      rec_rdata,
   output logic            rec_valid,
   output logic            rec_error,
   output logic            diag_irq,
   output logic            diag_irq_going,
   output logic            record_ready,
   output logic            status_red
);
   // pins from the field side pass two flops before use
   logic [7:0]  sense_s1_r;
   logic [7:0]  sense_s2_r;
   logic [7:0]  ovl_s1_r;
   logic [7:0]  ovl_s2_r;
   logic [3:0]  err_s1_r;
   logic [3:0]  err_s2_r;
   logic        ovl_any;
   logic [7:0]  fault_r;
   logic [7:0]  fault_nxt;
   logic [31:0] stamp_r;
   logic [31:0] ticker;
   logic [7:0]  rec_byte;
   logic        fault_any;
   logic        fault_rise;
   logic        fault_fall;
   logic        rec_hit;

   typedef enum logic [1:0] {
      DIAG_IDLE    = 2'b00,
      DIAG_COMING  = 2'b01,
      DIAG_ACTIVE  = 2'b11,
      DIAG_GOING   = 2'b10
   } diag_state_t;

   diag_state_t state_r;
   diag_state_t state_nxt;

   us_ticker #(
      .DIV     (US_DIV)
   ) u_ticker (
      .clk_sys (clk_sys),
      .rst     (rst),
      .count   (ticker)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sense_s1_r <= 8'h00;
         sense_s2_r <= 8'h00;
         ovl_s1_r   <= 8'h00;
         ovl_s2_r   <= 8'h00;
         err_s1_r   <= 4'h0;
         err_s2_r   <= 4'h0;
      end else begin
         sense_s1_r <= sense_channel;
         sense_s2_r <= sense_s1_r;
         ovl_s1_r   <= overload;
         ovl_s2_r   <= ovl_s1_r;
         err_s1_r   <= {param_error, external_error,
                        internal_error, module_failure};
         err_s2_r   <= err_s1_r;
      end
   end

   // fault byte follows its causes level for level
   assign ovl_any   = |ovl_s2_r;
   assign fault_nxt = {err_s2_r[3], 2'b00, ovl_any, 1'b0,
                       err_s2_r[2:0]};
   assign fault_any  = |fault_nxt;
   assign fault_rise = fault_any && (fault_r == 8'h00);
   assign fault_fall = !fault_any && (fault_r != 8'h00);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fault_r   <= 8'h00;
         stamp_r   <= STAMP_RESET;
      end else begin
         fault_r   <= fault_nxt;
         // stamp taken on entry and on exit of the fault
         if (fault_rise || fault_fall) begin
            stamp_r <= ticker;
         end
      end
   end

   // interrupt sequencer: coming, held until cause gone, going
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         DIAG_IDLE: begin
            if (fault_rise && diag_irq_enable) begin
               state_nxt = DIAG_COMING;
            end
         end
         DIAG_COMING: begin
            state_nxt = DIAG_ACTIVE;
         end
         DIAG_ACTIVE: begin
            if (!fault_any) begin
               state_nxt = DIAG_GOING;
            end
         end
         DIAG_GOING: begin
            state_nxt = DIAG_IDLE;
         end
         default: begin
            state_nxt = DIAG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r        <= DIAG_IDLE;
         diag_irq       <= 1'b0;
         diag_irq_going <= 1'b0;
         record_ready   <= 1'b0;
         status_red     <= 1'b0;
      end else begin
         state_r        <= state_nxt;
         diag_irq       <= (state_nxt == DIAG_COMING);
         diag_irq_going <= (state_nxt == DIAG_GOING);
         // set wins over the acknowledge
         if (state_nxt == DIAG_COMING || state_nxt == DIAG_GOING) begin
            record_ready <= 1'b1;
         end else if (irq_ack) begin
            record_ready <= 1'b0;
         end
         status_red     <= ovl_any;
      end
   end

   // record byte select; reserved bytes fall to zero
   assign rec_hit = rec_rd && (rec_number == DIAG_RECORD_NO);
   always_comb begin
      rec_byte = SPARE_RESET;
      case (rec_index)
         REC_FAULT:         rec_byte = fault_r;
         REC_CLASS:         rec_byte = CLASS_RESET;
         REC_KIND:          rec_byte = KIND_RESET;
         REC_BITS:          rec_byte = BITS_RESET;
         REC_COUNT:         rec_byte = COUNT_RESET;
         REC_STAMP:         rec_byte = stamp_r[7:0];
         REC_STAMP + 5'h01: rec_byte = stamp_r[15:8];
         REC_STAMP + 5'h02: rec_byte = stamp_r[23:16];
         REC_LAST:          rec_byte = stamp_r[31:24];
         default:           rec_byte = SPARE_RESET;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         input_image   <= 8'h00;
         output_image  <= OUT_RESET;
         drive_channel <= OUT_RESET;
         rec_rdata     <= 8'h00;
         rec_valid     <= 1'b0;
         rec_error     <= 1'b0;
      end else begin
         if (in_rd && in_addr == IMAGE_OFFSET) begin
            input_image <= sense_s2_r;
         end
         if (out_wr && out_addr == IMAGE_OFFSET) begin
            output_image  <= out_wdata;
            drive_channel <= out_wdata;
         end
         rec_valid <= rec_hit;
         rec_error <= rec_rd && !rec_hit;
         rec_rdata <= rec_hit ? rec_byte : 8'h00;
      end
   end

   // images, lamp and fault byte
   a_red_follows_ovl: assert property (
      @(posedge clk_sys) disable iff (rst)
      1'b1 |=> status_red == $past(ovl_any))
      else $error("red led wrong");
   a_fault_ovl: assert property (
      @(posedge clk_sys) disable iff (rst)
      1'b1 |=> fault_r[FAULT_OVERLOAD] == $past(ovl_any))
      else $error("overload fault bit wrong");
   a_fault_spare: assert property (
      @(posedge clk_sys) disable iff (rst)
      fault_r[3] == 1'b0 && fault_r[6:5] == 2'b00)
      else $error("reserved fault bits set");
   a_out_drive: assert property (
      @(posedge clk_sys) disable iff (rst)
      out_wr && out_addr == IMAGE_OFFSET |=>
         drive_channel == $past(out_wdata))
      else $error("output not driven");
   a_out_refused: assert property (
      @(posedge clk_sys) disable iff (rst)
      !(out_wr && out_addr == IMAGE_OFFSET) |=>
         $stable(output_image) && $stable(drive_channel))
      else $error("refused write landed");
   a_in_capture: assert property (
      @(posedge clk_sys) disable iff (rst)
      in_rd && in_addr == IMAGE_OFFSET |=> input_image == $past(sense_s2_r))
      else $error("input byte not captured");
   a_in_refused: assert property (
      @(posedge clk_sys) disable iff (rst)
      !(in_rd && in_addr == IMAGE_OFFSET) |=> $stable(input_image))
      else $error("refused read moved input byte");
   // interrupt sequencing
   a_irq_gated_off: assert property (
      @(posedge clk_sys) disable iff (rst)
      !diag_irq_enable && state_r == DIAG_IDLE |=> !diag_irq)
      else $error("irq while disabled");
   a_irq_on_entry: assert property (
      @(posedge clk_sys) disable iff (rst)
      fault_rise && diag_irq_enable && state_r == DIAG_IDLE |=> diag_irq)
      else $error("no incoming irq");
   a_irq_one_cycle: assert property (
      @(posedge clk_sys) disable iff (rst)
      diag_irq |=> !diag_irq)
      else $error("incoming irq too long");
   a_going_follows: assert property (
      @(posedge clk_sys) disable iff (rst)
      state_r == DIAG_ACTIVE && !fault_any |=> diag_irq_going)
      else $error("no going irq");
   a_ready_on_irq: assert property (
      @(posedge clk_sys) disable iff (rst)
      diag_irq |-> record_ready)
      else $error("record not ready");
   a_ready_on_going: assert property (
      @(posedge clk_sys) disable iff (rst)
      diag_irq_going |-> record_ready)
      else $error("going record not ready");
   a_stamp_event: assert property (
      @(posedge clk_sys) disable iff (rst)
      fault_rise |=> stamp_r == $past(ticker))
      else $error("stamp not taken");
   // record reads against the fixed layout
   a_rec_error: assert property (
      @(posedge clk_sys) disable iff (rst)
      rec_rd && rec_number != DIAG_RECORD_NO |=> rec_error && !rec_valid)
      else $error("wrong record not refused");
   a_rec_class: assert property (
      @(posedge clk_sys) disable iff (rst)
      rec_hit && rec_index == REC_CLASS |=> rec_valid && rec_rdata == 8'h0f)
      else $error("class byte wrong");
   a_rec_kind: assert property (
      @(posedge clk_sys) disable iff (rst)
      rec_hit && rec_index == REC_KIND |=> rec_rdata == 8'h72)
      else $error("kind byte wrong");
   a_rec_fault: assert property (
      @(posedge clk_sys) disable iff (rst)
      rec_hit && rec_index == REC_FAULT |=> rec_rdata == $past(fault_r))
      else $error("fault byte read wrong");
   a_rec_counts: assert property (
      @(posedge clk_sys) disable iff (rst)
      rec_hit && (rec_index == REC_BITS || rec_index == REC_COUNT) |=>
         rec_rdata == 8'h00)
      else $error("count bytes not zero");
   a_rec_spare: assert property (
      @(posedge clk_sys) disable iff (rst)
      rec_hit && (rec_index == 5'h02 || rec_index == 5'h03 ||
         (rec_index >= 5'h07 && rec_index < REC_STAMP)) |=>
         rec_rdata == 8'h00)
      else $error("reserved byte not zero");
   // skip event cycles, where the stamp itself moves
   a_rec_stamp: assert property (
      @(posedge clk_sys) disable iff (rst)
      rec_hit && rec_index == REC_STAMP && !fault_rise && !fault_fall |=>
         rec_rdata == stamp_r[7:0])
      else $error("stamp byte read wrong");

   c_incoming: cover property (@(posedge clk_sys) diag_irq);
   c_going: cover property (@(posedge clk_sys) diag_irq_going);
   c_rec_read: cover property (@(posedge clk_sys) rec_valid);
   c_rec_refused: cover property (@(posedge clk_sys) rec_error);
   c_quiet_red: cover property (@(posedge clk_sys)
      status_red && !diag_irq_enable);
endmodule

// ==== dv/cpu_model.sv ====
// controller side model issuing image and record requests
`timescale 1ns/1ps
module cpu_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] rec_rdata,
   input  wire logic       rec_valid,
   input  wire logic       rec_error,
   output logic            out_wr,
   output logic [7:0]      out_addr,
   output logic [7:0]      out_wdata,
   output logic            in_rd,
   output logic [7:0]      in_addr,
   output logic            rec_rd,
   output logic [7:0]      rec_number,
   output logic [4:0]      rec_index,
   output logic            irq_ack
);
   initial begin
      {out_wr, in_rd, rec_rd, irq_ack} = 4'h0;
      {out_addr, out_wdata, in_addr, rec_number} = 32'h0;
      rec_index = 5'h00;
   end
   // released lines are inverted so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      out_wr = 1'b1;
      out_addr = a;
      out_wdata = d;
      @(negedge clk_sys);
      out_wr = 1'b0;
      out_addr = ~a;
      out_wdata = ~d;
   endtask
   task automatic rd_in(input logic [7:0] a);
      @(negedge clk_sys);
      in_rd = 1'b1;
      in_addr = a;
      @(negedge clk_sys);
      in_rd = 1'b0;
      in_addr = ~a;
   endtask
   task automatic rd_rec(input logic [7:0] n, input logic [4:0] i,
                         output logic [7:0] d, output logic e);
      @(negedge clk_sys);
      rec_rd = 1'b1;
      rec_number = n;
      rec_index = i;
      @(negedge clk_sys);
      rec_rd = 1'b0;
      rec_number = ~n;
      rec_index = ~i;
      d = (rec_valid === 1'b1) ? rec_rdata : 8'hxx;
      e = rec_error;
   endtask
   task automatic ack;
      @(negedge clk_sys);
      irq_ack = 1'b1;
      @(negedge clk_sys);
      irq_ack = 1'b0;
   endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the mixed input/output diagnostic port
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
   logic       clk_sys = 1'b0, rst = 1'b1, diag_irq_enable = 1'b0;
   logic [7:0] sense_channel = 8'h00, overload = 8'h00;
   logic       module_failure = 0, internal_error = 0;
   logic       external_error = 0, param_error = 0;
   logic       out_wr, in_rd, rec_rd, irq_ack, rec_valid, rec_error;
   logic       diag_irq, diag_irq_going, record_ready, status_red;
   logic [7:0] out_addr, out_wdata, in_addr, rec_number, rec_rdata;
   logic [7:0] input_image, output_image, drive_channel;
   logic [4:0] rec_index;
   int         n_errors = 0, checked = 0, ticks = 0, t0 = 0;
   always #2.5 clk_sys = ~clk_sys;
   mixed_io_diag_port #(.US_DIV(4)) mixed_io_diag_port_i (
      .clk_sys(clk_sys), .rst(rst), .sense_channel(sense_channel),
      .overload(overload), .diag_irq_enable(diag_irq_enable),
      .module_failure(module_failure), .internal_error(internal_error),
      .external_error(external_error), .param_error(param_error),
      .out_wr(out_wr), .out_addr(out_addr), .out_wdata(out_wdata),
      .in_rd(in_rd), .in_addr(in_addr), .rec_rd(rec_rd),
      .rec_number(rec_number), .rec_index(rec_index), .irq_ack(irq_ack),
      .input_image(input_image), .output_image(output_image),
      .drive_channel(drive_channel), .rec_rdata(rec_rdata),
      .rec_valid(rec_valid), .rec_error(rec_error), .diag_irq(diag_irq),
      .diag_irq_going(diag_irq_going), .record_ready(record_ready),
      .status_red(status_red));
   cpu_model cpu_model_i (
      .clk_sys(clk_sys), .rec_rdata(rec_rdata), .rec_valid(rec_valid),
      .rec_error(rec_error), .out_wr(out_wr), .out_addr(out_addr),
      .out_wdata(out_wdata), .in_rd(in_rd), .in_addr(in_addr),
      .rec_rd(rec_rd), .rec_number(rec_number), .rec_index(rec_index),
      .irq_ack(irq_ack));
   task automatic end_of_test;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      ticks <= ticks + 1;
      if (ticks == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   // stamp accepted within two microseconds of the bench's own count
   task automatic chk_stamp(input int t);
      logic [7:0]  d;
      logic        e;
      logic [31:0] s, x;
      for (int i = 0; i < 4; i++) begin
         cpu_model_i.rd_rec(8'h01, 5'(16 + i), d, e);
         s[8*i +: 8] = d;
      end
      x = 32'((t - t0) / 4);
      `CHK((s + 32'd2 - x) <= 32'd4, 1'b1)
   endtask
   task automatic t_images;
      @(negedge clk_sys);
      sense_channel = 8'ha5;
      repeat (4) @(negedge clk_sys);
      cpu_model_i.rd_in(8'h00);
      `CHK(input_image, 8'ha5)
      sense_channel = 8'h5a;
      repeat (4) @(negedge clk_sys);
      cpu_model_i.rd_in(8'h01);
      `CHK(input_image, 8'ha5)
      cpu_model_i.rd_in(8'h00);
      `CHK(input_image, 8'h5a)
      cpu_model_i.wr(8'h00, 8'h3c);
      `CHK(drive_channel, 8'h3c)
      cpu_model_i.wr(8'h02, 8'hc3);
      `CHK(output_image, 8'h3c)
      cpu_model_i.wr(8'h00, 8'hc3);
      `CHK(drive_channel, 8'hc3)
   endtask
   task automatic t_record;
      logic [7:0] d;
      logic       e;
      for (int i = 0; i < 16; i++) begin
         cpu_model_i.rd_rec(8'h01, 5'(i), d, e);
         `CHK(d, (i == 1) ? 8'h0f : (i == 4) ? 8'h72 : 8'h00)
      end
      cpu_model_i.rd_rec(8'h02, 5'd1, d, e);
      `CHK(e, 1'b1)
   endtask
   task automatic t_overload;
      logic [7:0] d;
      logic       e;
      int         t;
      diag_irq_enable = 1'b1;
      overload = 8'h08;
      for (int k = 0; k < 10 && diag_irq !== 1'b1; k++) @(negedge clk_sys);
      t = ticks;
      `CHK(diag_irq, 1'b1)
      `CHK(status_red, 1'b1)
      `CHK(record_ready, 1'b1)
      cpu_model_i.rd_rec(8'h01, 5'd0, d, e);
      `CHK(d, 8'h10)
      `CHK(diag_irq, 1'b0)
      chk_stamp(t);
      overload = 8'h00;
      for (int k = 0; k < 10 && diag_irq_going !== 1'b1; k++)
         @(negedge clk_sys);
      t = ticks;
      `CHK(diag_irq_going, 1'b1)
      `CHK(status_red, 1'b0)
      cpu_model_i.rd_rec(8'h01, 5'd0, d, e);
      `CHK(d, 8'h00)
      chk_stamp(t);
      cpu_model_i.ack();
      `CHK(record_ready, 1'b0)
   endtask
   task automatic t_quiet;
      logic [7:0] d;
      logic       e, seen;
      seen = 1'b0;
      diag_irq_enable = 1'b0;
      overload = 8'h80;
      repeat (8) @(negedge clk_sys) seen |= diag_irq;
      `CHK(seen, 1'b0)
      `CHK(status_red, 1'b1)
      {module_failure, internal_error, external_error, param_error} = 4'hf;
      repeat (5) @(negedge clk_sys);
      cpu_model_i.rd_rec(8'h01, 5'd0, d, e);
      `CHK(d, 8'h97)
      {module_failure, internal_error, external_error, param_error} = 4'h0;
      overload = 8'h00;
      repeat (5) @(negedge clk_sys);
      `CHK(status_red, 1'b0)
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      t0 = ticks;
      `CHK({diag_irq, status_red, record_ready}, 3'h0)
      `CHK(output_image, 8'h00)
      t_images();
      t_record();
      t_overload();
      t_quiet();
      end_of_test();
   end
endmodule
